// >>> common/fps_pkg.sv
// Fault protection supervisor: shared constants and types.
// Assumes a single 250 MHz clock and a synchronous active-low reset.
package fps_pkg;
  // Clock and time base
  localparam int CLK_PERIOD_NS = 4;
  localparam int SEC_NS        = 1_000_000_000;
  localparam int HALF_SEC_CYC  = SEC_NS / (2 * CLK_PERIOD_NS);
  localparam int HC_W          = 28;

  // Seconds thresholds, counted on the one-second tick
  localparam int TMR_W = 6;
  localparam logic [TMR_W-1:0] LAMP_TEST_S   = 6'h01;
  localparam logic [TMR_W-1:0] PWRUP_BLINK_S = 6'h03;
  localparam logic [TMR_W-1:0] SHUT_S        = 6'h0a;
  localparam logic [TMR_W-1:0] SLEEP_S       = 6'h3c;

  // Register map (byte addresses) and fields
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STAT = 8'h04;
  localparam logic [ADDR_W-1:0] REG_TMR  = 8'h08;
  localparam int CTRL_ON_B   = 0;
  localparam int CTRL_OFF_B  = 1;
  localparam int CTRL_RNG_LO = 4;
  localparam logic [1:0] RNG_RST    = 2'h0;
  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [2:0] {
    ST_LAMP  = 3'h0,
    ST_ROM   = 3'h1,
    ST_RUN   = 3'h3,
    ST_ERR   = 3'h2,
    ST_SLEEP = 3'h6
  } fps_state_t;

  typedef struct packed {
    logic ovl;
    logic temp;
    logic vout;
    logic supply_low;
  } fps_fault_t;

  typedef struct packed {
    logic       overload;
    logic       out_sw;
    logic [2:0] range;
  } fps_lamp_t;
endpackage

// >>> rtl/fps_supervisor.sv
// Power-on self-diagnosis and protection supervisor with AXI4-Lite registers.
// Assumes fault inputs and the switch are already synchronous to aclk;
// the program-memory checksum engine reports through rom_done / rom_ok.
//
// Overview of operation
// - At power-up run lamp test then checksum; any failure enters error state.
// - Lamp test lights all lamps one second; output switch lamp stays dark.
// - Checksum failure locks the device out of all further operation.
// - An invalid operator operation also enters the error state.
// - Overload present: overload lamp steady, output enable requests ignored.
// - Overload lasting 10 s turns output off and blinks switch lamp.
// - Output switch press clears a latched overload shutdown.
// - Overload lasting 60 s enters sleep, overload lamp blinks, nothing accepted.
// - Over-temperature present: overload lamp steady, output enable blocked.
// - Over-temperature lasting 10 s turns output off, switch lamp blinks.
// - Output switch press clears a latched over-temperature shutdown.
// - Over-temperature lasting 60 s enters sleep; only power cycle recovers.
// - Abnormal output voltage: overload lamp steady, output enable blocked.
// - Abnormal voltage with output on turns output off at once, lamp blinks.
// - Abnormal voltage lasting 60 s enters sleep with overload lamp blinking.
// - Low internal supply makes every range lamp blink.
// - Range lamp blinking at power-up stops after about 3 seconds.
// - While range lamps blink, all operator operations are ignored.
`timescale 1ns/100ps
module fps_supervisor
  import fps_pkg::*;
#(
  parameter int HALF_CYC = HALF_SEC_CYC,
  parameter int NPANEL   = 8
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire fps_fault_t        faults,
  input  wire logic              sw_press,
  input  wire logic              invalid_op,
  input  wire logic              rom_done,
  input  wire logic              rom_ok,
  output logic [NPANEL-1:0]      panel_lamps,
  output fps_lamp_t              lamps,
  output logic                   output_enable,
  output logic                   sleep_state,
  output logic                   error_state
);

  function automatic logic [TMR_W-1:0] sat_inc(input logic [TMR_W-1:0] v);
    sat_inc = (&v) ? v : v + 6'h01;
  endfunction

  function automatic logic [2:0] rng_dec(input logic [1:0] r);
    case (r)
      2'h0:    rng_dec = 3'h1;
      2'h1:    rng_dec = 3'h2;
      2'h2:    rng_dec = 3'h4;
      default: rng_dec = 3'h0;
    endcase
  endfunction

  fps_state_t        st_r, st_nxt;
  logic [HC_W-1:0]   hc_r;
  logic              blink_r;
  logic [TMR_W-1:0]  up_s_r;
  logic [TMR_W-1:0]  t_ovl_r, t_tmp_r, t_vout_r;
  logic              out_on_r, out_on_nxt;
  logic              shut_r, shut_nxt;
  logic              rom_bad_r;
  logic              sw_d_r;
  logic [1:0]        rng_r;
  fps_lamp_t         lamps_r, lamps_nxt;
  logic [NPANEL-1:0] panel_r;

  // Time base
  wire half_tick = hc_r == HC_W'(HALF_CYC - 1);
  wire sec_tick  = half_tick & blink_r;

  // AXI write path
  logic              aw_hold_r, w_hold_r, bvalid_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0]       wdata_r;
  logic              wstrb0_r;
  logic              rvalid_r;
  logic [31:0]       rdata_r;
  logic [1:0]        rresp_r, bresp_r;

  wire wr_fire  = aw_hold_r & w_hold_r & ~bvalid_r;
  wire wr_ctrl  = wr_fire & (awaddr_r == REG_CTRL) & wstrb0_r;
  wire wr_known = (awaddr_r == REG_CTRL) | (awaddr_r == REG_STAT) | (awaddr_r == REG_TMR);
  wire wr_on    = wr_ctrl & wdata_r[CTRL_ON_B];
  wire wr_off   = wr_ctrl & wdata_r[CTRL_OFF_B];
  wire [1:0] wr_rng = wdata_r[CTRL_RNG_LO +: 2];

  // Operator operations and their gating
  wire sw_edge    = sw_press & ~sw_d_r;
  wire pwr_blink  = up_s_r < PWRUP_BLINK_S;
  wire rng_blink  = faults.supply_low | pwr_blink;
  wire running    = st_r == ST_RUN;
  wire ops_ok     = running & ~rng_blink;
  wire bad_op     = invalid_op | (wr_on & wr_off);
  wire any_fault  = faults.ovl | faults.temp | faults.vout;

  wire long_fault = (t_ovl_r >= SLEEP_S) | (t_tmp_r >= SLEEP_S)
                  | (t_vout_r >= SLEEP_S);
  wire trip       = (t_ovl_r >= SHUT_S) | (t_tmp_r >= SHUT_S)
                  | (faults.vout & out_on_r);
  // Register on request obeys the shutdown latch, as the switch does
  wire on_req     = (sw_edge | wr_on) & ~out_on_r & ~shut_r;
  wire off_req    = (sw_edge & out_on_r) | wr_off;

  // Fault timers restart whenever their fault is absent
  function automatic logic [TMR_W-1:0] tmr_next(input logic f, input logic [TMR_W-1:0] t);
    tmr_next = !f ? '0 : (sec_tick ? sat_inc(t) : t);
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hc_r    <= '0;
      blink_r <= 1'b0;
      up_s_r  <= '0;
      sw_d_r  <= 1'b0;
    end else begin
      hc_r    <= half_tick ? '0 : hc_r + HC_W'(1);
      blink_r <= blink_r ^ half_tick;
      up_s_r  <= sec_tick ? sat_inc(up_s_r) : up_s_r;
      sw_d_r  <= sw_press;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      t_ovl_r  <= '0;
      t_tmp_r  <= '0;
      t_vout_r <= '0;
    end else begin
      t_ovl_r  <= tmr_next(faults.ovl & running, t_ovl_r);
      t_tmp_r  <= tmr_next(faults.temp & running, t_tmp_r);
      t_vout_r <= tmr_next(faults.vout & running, t_vout_r);
    end
  end

  // Sequence: lamp test, checksum, run, error, sleep
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_LAMP:  if (up_s_r >= LAMP_TEST_S) st_nxt = ST_ROM;
      ST_ROM:   if (rom_done) st_nxt = rom_ok ? ST_RUN : ST_ERR;
      ST_RUN: begin
        if (long_fault) st_nxt = ST_SLEEP;
        else if (bad_op && !rng_blink) st_nxt = ST_ERR;
      end
      ST_ERR:   if (!rom_bad_r && sw_edge && !rng_blink) st_nxt = ST_RUN;
      ST_SLEEP: st_nxt = ST_SLEEP;
      default:  st_nxt = ST_ERR;
    endcase
  end

  // Shutdown latch: a new trip wins over a clearing press
  assign shut_nxt = trip ? 1'b1 : ((ops_ok && sw_edge) ? 1'b0 : shut_r);

  always_comb begin
    out_on_nxt = out_on_r;
    if (!running || trip || long_fault || (ops_ok && bad_op)) out_on_nxt = 1'b0;
    else if (ops_ok && off_req) out_on_nxt = 1'b0;
    else if (ops_ok && on_req && !any_fault) out_on_nxt = 1'b1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r      <= ST_LAMP;
      out_on_r  <= 1'b0;
      shut_r    <= 1'b0;
      rom_bad_r <= 1'b0;
      rng_r     <= RNG_RST;
    end else begin
      st_r      <= st_nxt;
      out_on_r  <= out_on_nxt;
      shut_r    <= running & shut_nxt;
      rom_bad_r <= rom_bad_r | (st_r == ST_ROM && rom_done && !rom_ok);
      if (wr_ctrl && ops_ok && !bad_op) rng_r <= wr_rng;
    end
  end

  // Lamp drive
  always_comb begin
    lamps_nxt.overload = any_fault;
    lamps_nxt.out_sw   = shut_r ? blink_r : out_on_r;
    lamps_nxt.range    = rng_blink ? {3{blink_r}} : rng_dec(rng_r);
    if (st_r == ST_SLEEP) lamps_nxt.overload = blink_r;
    if (st_r == ST_LAMP) begin
      lamps_nxt.overload = 1'b1;
      lamps_nxt.out_sw   = 1'b0;
      lamps_nxt.range    = 3'h7;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lamps_r <= '0;
      panel_r <= '0;
    end else begin
      lamps_r <= lamps_nxt;
      panel_r <= {NPANEL{st_r == ST_LAMP}};
    end
  end

  assign lamps         = lamps_r;
  assign panel_lamps   = panel_r;
  assign output_enable = out_on_r;
  assign sleep_state   = st_r == ST_SLEEP;
  assign error_state   = st_r == ST_ERR;

  // AXI4-Lite slave
  assign s_axi_awready = ~aw_hold_r & ~bvalid_r;
  assign s_axi_wready  = ~w_hold_r & ~bvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = ~rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  wire [31:0] stat_word = {16'h0, 3'h0, rom_bad_r, rng_blink, any_fault, shut_r, out_on_r,
                           faults, 1'b0, st_r};
  wire [31:0] tmr_word  = {8'h0, 2'h0, t_vout_r, 2'h0, t_tmp_r, 2'h0, t_ovl_r};
  wire [31:0] ctrl_word = {26'h0, rng_r, 4'h0};
  wire        rd_known  = (s_axi_araddr == REG_CTRL) | (s_axi_araddr == REG_STAT)
                        | (s_axi_araddr == REG_TMR);
  wire [31:0] rd_mux    = (s_axi_araddr == REG_CTRL) ? ctrl_word :
                          (s_axi_araddr == REG_STAT) ? stat_word :
                          (s_axi_araddr == REG_TMR)  ? tmr_word  : 32'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
      awaddr_r  <= '0;
      wdata_r   <= '0;
      wstrb0_r  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb0_r <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_hold_r <= 1'b0;
        w_hold_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= wr_known ? RESP_OKAY : RESP_DECERR;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= '0;
      rresp_r  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_mux;
      rresp_r  <= rd_known ? RESP_OKAY : RESP_DECERR;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  lamp_test_a: assert property (st_r == ST_LAMP |=> lamps_r.overload && !lamps_r.out_sw
    && lamps_r.range == 3'h7 && &panel_r)
    else $error("lamp test pattern wrong");
  rom_fail_a: assert property (st_r == ST_ROM && rom_done && !rom_ok
    |=> st_r == ST_ERR ##1 (st_r == ST_ERR && !out_on_r)[*3])
    else $error("checksum failure not locked out");
  bad_op_a: assert property (running && bad_op && !rng_blink && !long_fault
    |=> st_r == ST_ERR && !out_on_r)
    else $error("invalid operation did not enter error state");
  err_out_off_a: assert property (st_r == ST_ERR |-> !out_on_r)
    else $error("output on in error state");
  fault_block_a: assert property (!out_on_r && any_fault |=> !out_on_r)
    else $error("output enabled during a fault");
  temp_block_a: assert property (!out_on_r && faults.temp |=> !out_on_r)
    else $error("output enabled during over-temperature");
  vout_block_a: assert property (!out_on_r && faults.vout |=> !out_on_r)
    else $error("output enabled during abnormal voltage");
  ten_sec_a: assert property (running && (t_ovl_r >= SHUT_S || t_tmp_r >= SHUT_S)
    |=> !out_on_r && shut_r ##1 lamps_r.out_sw == $past(blink_r))
    else $error("ten second shutdown missing");
  vout_trip_a: assert property (running && faults.vout && out_on_r |=> !out_on_r && shut_r)
    else $error("abnormal voltage did not cut output");
  sleep_entry_a: assert property (running && long_fault |=> st_r == ST_SLEEP && !out_on_r
    ##1 lamps_r.overload == $past(blink_r))
    else $error("sleep not entered after long fault");
  sleep_hold_a: assert property (st_r == ST_SLEEP |=> st_r == ST_SLEEP && !out_on_r)
    else $error("sleep state left");
  shut_clr_a: assert property (shut_r && !trip && ops_ok && sw_edge |=> !shut_r && !out_on_r)
    else $error("switch press did not clear shutdown");
  shut_hold_a: assert property (shut_r |-> !out_on_r)
    else $error("output on while shutdown latched");
  timer_clr_a: assert property (!faults.ovl |=> t_ovl_r == '0)
    else $error("overload timer not restarted");
  supply_lamp_a: assert property (st_r != ST_LAMP && faults.supply_low
    |=> lamps_r.range == {3{$past(blink_r)}})
    else $error("range lamps not blinking on supply fault");
  supply_ign_a: assert property (rng_blink && !out_on_r |=> !out_on_r)
    else $error("operation accepted during supply blink");
  tick_a: assert property (sec_tick |=> !sec_tick[*2])
    else $error("second tick malformed");

  run_c:   cover property (st_r == ST_ROM && rom_done && rom_ok ##1 running);
  on_c:    cover property (!out_on_r ##1 out_on_r);
  trip_c:  cover property (out_on_r && trip ##1 shut_r);
  sleep_c: cover property (running ##1 st_r == ST_SLEEP);

endmodule

// >>> dv/fps_panel_model.sv
// Far side of the supervisor: fault sensors, output switch, checksum engine.
// Assumes the bench sets fault levels and asks for presses just after aclk edges.
`timescale 1ns/100ps
module fps_panel_model
  import fps_pkg::*;
#(
  parameter int CKS_LAT = 5
) (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire fps_fault_t fault_req,
  input  wire logic       press_req,
  input  wire logic       rom_good,
  output fps_fault_t      faults,
  output logic            sw_press,
  output logic            rom_done,
  output logic            rom_ok
);
  logic [3:0] cnt_r;
  logic [1:0] hold_r;

  always_ff @(posedge aclk) begin
    faults <= fault_req;
    if (!aresetn) begin
      cnt_r    <= 4'h0;
      rom_done <= 1'h0;
      rom_ok   <= 1'h0;
      hold_r   <= 2'h0;
    end else begin
      if (cnt_r != 4'(CKS_LAT)) cnt_r <= cnt_r + 4'h1;
      else rom_done <= 1'h1;
      // Result is meaningless before done, so keep it moving
      rom_ok <= rom_done ? rom_good : ~rom_ok;
      // Contact held a few cycles; one hold is one press
      if (press_req) hold_r <= 2'h3;
      else if (hold_r != 2'h0) hold_r <= hold_r - 2'h1;
    end
  end

  assign sw_press = (hold_r != 2'h0);
endmodule

// >>> dv/test_fps_supervisor.sv
// Self-checking bench for the fault protection supervisor.
// Assumes HALF_CYC shortened to 8, so one second is 16 clocks.
`timescale 1ns/100ps
module test_fps_supervisor
  import fps_pkg::*;
;
  localparam int S = 16;
  typedef struct packed {logic [31:0] d; logic [31:0] m; logic [1:0] r;} fps_exp_t;
  logic              aclk = 1'h0, aresetn = 1'h0, invalid_op = 1'h0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic              s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic              s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [31:0]       s_axi_wdata = '0, s_axi_rdata;
  logic [3:0]        s_axi_wstrb = 4'hf;
  logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]        s_axi_bresp, s_axi_rresp, rng;
  fps_fault_t        faults, f, fault_req = '0;
  logic              sw_press, rom_done, rom_ok, press_req = 1'h0, rom_good = 1'h0;
  logic [7:0]        panel_lamps;
  fps_lamp_t         lamps, lo_or, lo_and;
  logic              output_enable, sleep_state, error_state;
  fps_exp_t          q[$], e;
  int                n_errors = 0, checked = 0;

  fps_supervisor #(.HALF_CYC(8), .NPANEL(8)) u_fps_supervisor (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .faults,
    .sw_press, .invalid_op, .rom_done, .rom_ok, .panel_lamps, .lamps, .output_enable,
    .sleep_state, .error_state);
  fps_panel_model u_fps_panel_model (.aclk, .aresetn, .fault_req, .press_req, .rom_good,
    .faults, .sw_press, .rom_done, .rom_ok);

  always #2 aclk = ~aclk;

  task automatic cmp(input logic [31:0] g, input logic [31:0] x);
    checked++;
    if (g !== x) begin
      n_errors++;
      $display("mismatch at %0t got %h exp %h", $time, g, x);
    end
  endtask

  // Responses are taken in the order the requests were noted
  always @(posedge aclk) begin
    if (s_axi_bvalid && s_axi_bready) begin
      e = q.pop_front();
      cmp(s_axi_bresp, e.r);
    end
    if (s_axi_rvalid && s_axi_rready) begin
      e = q.pop_front();
      cmp(s_axi_rdata & e.m, e.d);
      cmp(s_axi_rresp, e.r);
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // Ready stays up after a call, so back-to-back calls never retoggle it;
  // only the watchdog ends a wait for an answer
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rs);
    q.push_back('{d: '0, m: '0, r: rs});
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid  <= 1'h1;
    s_axi_bready  <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d, m, input logic [1:0] rs);
    q.push_back('{d: d, m: m, r: rs});
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready  <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
  endtask

  task automatic look(input int n);
    lo_or  = '0;
    lo_and = '1;
    repeat (n) begin
      @(posedge aclk);
      lo_or  = lo_or | lamps;
      lo_and = lo_and & lamps;
    end
  endtask

  task automatic press();
    press_req <= 1'h1;
    @(posedge aclk);
    press_req <= 1'h0;
    tick(8);
  endtask

  task automatic boot(input logic good);
    rom_good <= good;
    aresetn  <= 1'h0;
    tick(3);
    aresetn <= 1'h1;
    tick(8);
    cmp(panel_lamps, 8'hff);
    cmp(lamps.out_sw, 1'h0);
    tick(S);
    cmp(panel_lamps, 8'h00);
  endtask

  task automatic end_of_test();
    $display("checked %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    void'($urandom(32'h8bc9));
    boot(1'h0);
    cmp(error_state, 1'h1);
    tick(2 * S);
    press();
    wr(REG_CTRL, 32'h1, RESP_OKAY);
    rd(REG_STAT, 32'h1002, 32'h1107, RESP_OKAY);
    cmp(error_state, 1'h1);
    $display("test checksum done");
    boot(1'h1);
    wr(REG_CTRL, 32'h1, RESP_OKAY);
    rd(REG_STAT, 32'h0803, 32'h0907, RESP_OKAY);
    tick(2 * S);
    rd(REG_STAT, 32'h0003, 32'h0907, RESP_OKAY);
    rd(8'h0c, 32'h0, 32'hffffffff, RESP_DECERR);
    wr(8'h0c, 32'h1, RESP_DECERR);
    invalid_op <= 1'h1;
    tick(1);
    invalid_op <= 1'h0;
    tick(2);
    cmp(error_state, 1'h1);
    press();
    cmp(error_state, 1'h0);
    wr(REG_CTRL, 32'h3, RESP_OKAY);
    tick(2);
    cmp(error_state, 1'h1);
    press();
    $display("test start-up done");
    rng = 2'($urandom % 4);
    wr(REG_CTRL, {26'h0, rng, 4'h1}, RESP_OKAY);
    tick(2);
    cmp(output_enable, 1'h1);
    cmp(lamps.range, rng == 2'h3 ? 3'h0 : 3'h1 << rng);
    rd(REG_CTRL, {26'h0, rng, 4'h0}, 32'h30, RESP_OKAY);
    fault_req <= fps_fault_t'(4'h1);
    tick(3);
    rd(REG_STAT, 32'h0810, 32'h08f0, RESP_OKAY);
    wr(REG_CTRL, 32'h2, RESP_OKAY);
    cmp(output_enable, 1'h1);
    look(2 * S);
    cmp(lo_or.range, 3'h7);
    cmp(lo_and.range, 3'h0);
    fault_req <= '0;
    tick(3);
    wr(REG_CTRL, 32'h2, RESP_OKAY);
    $display("test supply done");
    for (int i = 0; i < 3; i++) begin
      f = fps_fault_t'(4'h8 >> i);
      if (i > 0) begin
        boot(1'h1);
        tick(3 * S);
      end
      if (i < 2) begin
        fault_req <= f;
        tick(5 * S);
        wr(REG_CTRL, 32'h1, RESP_OKAY);
        cmp(output_enable, 1'h0);
        fault_req <= '0;
        tick(3);
        rd(REG_TMR, 32'h0, 32'h3f << (8 * i), RESP_OKAY);
        wr(REG_CTRL, 32'h1, RESP_OKAY);
        fault_req <= f;
        tick(8 * S);
        cmp(output_enable, 1'h1);
        tick(3 * S);
      end else begin
        wr(REG_CTRL, 32'h1, RESP_OKAY);
        fault_req <= f;
        tick(4);
        cmp(output_enable, 1'h0);
        wr(REG_CTRL, 32'h1, RESP_OKAY);
        cmp(output_enable, 1'h0);
      end
      rd(REG_STAT, 32'h200, 32'h300, RESP_OKAY);
      look(2 * S);
      cmp(lo_and.overload, 1'h1);
      cmp(lo_or.out_sw & ~lo_and.out_sw, 1'h1);
      fault_req <= '0;
      tick(3);
      press();
      rd(REG_STAT, 32'h0, 32'h300, RESP_OKAY);
      press();
      cmp(output_enable, 1'h1);
      fault_req <= f;
      tick(58 * S);
      cmp(sleep_state, 1'h0);
      tick(3 * S);
      cmp(sleep_state, 1'h1);
      look(2 * S);
      cmp(lo_or.overload & ~lo_and.overload, 1'h1);
      fault_req <= '0;
      press();
      wr(REG_CTRL, 32'h1, RESP_OKAY);
      rd(REG_STAT, 32'h6, 32'h107, RESP_OKAY);
      $display("test fault %0d done", i);
    end
    end_of_test();
  end

  // Whole run is near 4200 clocks; this span leaves a wide margin
  initial begin
    #100000;
    n_errors++;
    end_of_test();
  end
endmodule
